/* logic/cam_config_status_regs.sv */
`timescale 1ns/100ps
`include "cam_regs_consts.svh"

module cam_config_status_regs #(
    parameter int ADDR_W        = 13,
    parameter bit SMALL_VARIANT = 1'b0
) (
    // Clock and reset
    input  wire logic                             clk_sys,
    input  wire logic                             resetn,
    // Control and data pins
    input  wire cam_regs_pkg::bus_pins_s          bus_pins,
    output logic                           [31:0] dq_out,
    output logic                                  dq_oe,
    // Compare engine state
    input  wire cam_regs_pkg::engine_status_s     engine_status,
    // Configuration to the rest of the device
    output cam_regs_pkg::config_s                 config_fields,
    output logic                                  sw_control,
    output logic                                  device_selected
);

    localparam cam_regs_pkg::bus_pins_s PINS_IDLE = '{
        chip_enable_n:          1'b1,
        write_n:                1'b1,
        addr_valid_qualifier_n: 1'b0,
        reg_code:               2'h0,
        data:                   32'h0000_0000
    };

    cam_regs_pkg::bus_pins_s     pins_s;
    cam_regs_pkg::config_s       config_q;
    cam_regs_pkg::dev_select_s   dev_select_q;
    cam_regs_pkg::bus_state_e    bus_state_q;
    logic                        ce_prev_n_q;
    logic                        access_start;
    logic                        access_end;
    logic [1:0]                  target_code;
    logic                        sw_control_q;
    logic                        device_selected_q;
    logic [31:0]                 dq_out_q;
    logic                        dq_oe_q;
    logic                        write_access;
    logic                        read_access;
    logic                        config_write;
    logic                        dsel_write;
    logic [31:0]                 read_word;

    // Only the 13-bit location field is served
    if (ADDR_W != 13)
    begin : g_addr_check
        $error("cam_config_status_regs: address field is fixed at 13 bits");
    end

    // Every bus pin crosses through the same three-stage filter
    pin_sync #(
        .WIDTH ($bits(cam_regs_pkg::bus_pins_s)),
        .INIT  (PINS_IDLE)
    ) u_pin_sync (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .async_in (bus_pins),
        .sync_out (pins_s)
    );

    // Location field, top bit held low on the small variant
    function automatic logic [12:0] location_field(input logic [12:0] loc);
        logic [12:0] v;
        v = loc;
        if (SMALL_VARIANT)
            v[12] = 1'b0;
        return v;
    endfunction

    // Only code 11 selects software control
    function automatic logic is_software_mode(input cam_regs_pkg::ctrl_mode_e mode);
        return mode == cam_regs_pkg::MODE_SOFTWARE;
    endfunction

    // Fields taken from a written word
    function automatic cam_regs_pkg::config_s config_from_data(input logic [31:0] d);
        cam_regs_pkg::config_s c;
        c.mask_source       = d[`CFG_MASK_HI:`CFG_MASK_LO];
        c.ctrl_mode         = cam_regs_pkg::ctrl_mode_e'(d[`CFG_MODE_HI:`CFG_MODE_LO]);
        c.low_priority_flag = d[`CFG_LPF_BIT];
        c.page_code         = d[`CFG_PAGE_HI:`CFG_PAGE_LO];
        return c;
    endfunction

    function automatic cam_regs_pkg::dev_select_s dsel_from_data(input logic [31:0] d);
        cam_regs_pkg::dev_select_s s;
        s.select_enable_n = d[`DSEL_EN_BIT];
        s.select_code     = d[`DSEL_CODE_HI:`DSEL_CODE_LO];
        return s;
    endfunction

    function automatic logic [31:0] config_word(input cam_regs_pkg::config_s c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`CFG_MASK_HI:`CFG_MASK_LO] = c.mask_source;
        w[`CFG_MODE_HI:`CFG_MODE_LO] = c.ctrl_mode;
        w[`CFG_LPF_BIT]              = c.low_priority_flag;
        w[`CFG_PAGE_HI:`CFG_PAGE_LO] = c.page_code;
        return w;
    endfunction

    function automatic logic [31:0] status_word(input cam_regs_pkg::engine_status_s e,
                                                input logic [3:0] page);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`STS_HIT_BIT]   = e.hit_flag_n;
        w[`STS_MULTI_BIT] = e.multi_hit_flag_n;
        w[`STS_FULL_BIT]  = e.array_full_flag_n;
        w[`STS_TYPE_HI:`STS_TYPE_LO] = (e.addr_type == cam_regs_pkg::ADDR_TYPE_RSVD)
                                       ? cam_regs_pkg::ADDR_TYPE_RESET : e.addr_type;
        w[`STS_PAGE_HI:`STS_PAGE_LO] = page;
        w[`STS_ADDR_HI:`STS_ADDR_LO] = location_field(e.current_location);
        return w;
    endfunction

    function automatic logic [31:0] next_free_word(input cam_regs_pkg::engine_status_s e,
                                                   input logic [3:0] page);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`STS_PAGE_HI:`STS_PAGE_LO] = page;
        w[`STS_ADDR_HI:`STS_ADDR_LO] = location_field(e.next_empty_location);
        return w;
    endfunction

    function automatic logic [31:0] dev_select_word(input cam_regs_pkg::dev_select_s d);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`DSEL_EN_BIT]                = d.select_enable_n;
        w[`DSEL_CODE_HI:`DSEL_CODE_LO] = d.select_code;
        return w;
    endfunction

    // Access begins on the falling edge of the settled chip enable
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            ce_prev_n_q <= 1'b1;
        else
            ce_prev_n_q <= pins_s.chip_enable_n;
    end

    assign access_start = ce_prev_n_q && !pins_s.chip_enable_n;
    assign access_end   = pins_s.chip_enable_n;

    always_comb
    begin
        if (is_software_mode(config_q.ctrl_mode) && pins_s.addr_valid_qualifier_n)
            target_code = `REG_CODE_STATUS;
        else
            target_code = pins_s.reg_code;
    end

    // Writes commit once, at the start of an access
    assign write_access = access_start && !pins_s.write_n;
    assign read_access  = access_start && pins_s.write_n;
    assign config_write = write_access && (target_code == `REG_CODE_CONFIG);
    assign dsel_write   = write_access && (target_code == `REG_CODE_DEV_SELECT);

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            config_q.mask_source       <= `RST_MASK_SRC;
            config_q.ctrl_mode         <= cam_regs_pkg::ctrl_mode_e'(`RST_CTRL_MODE);
            config_q.low_priority_flag <= `RST_LOW_PRIO;
            config_q.page_code         <= `RST_PAGE;
        end
        else if (config_write)
            config_q <= config_from_data(pins_s.data);
    end

    // Device select register write
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            dev_select_q.select_enable_n <= `RST_SEL_EN_N;
            dev_select_q.select_code     <= `RST_SEL_CODE;
        end
        else if (dsel_write)
            dev_select_q <= dsel_from_data(pins_s.data);
    end

    // only code 11 is software control
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            sw_control_q <= 1'b1;
        else
            sw_control_q <= is_software_mode(config_q.ctrl_mode);
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            device_selected_q <= 1'b0;
        else
            device_selected_q <= !dev_select_q.select_enable_n
                                 && (config_q.page_code == dev_select_q.select_code);
    end

    // Word presented for the register being read
    always_comb
    begin
        read_word = 32'h0000_0000;
        unique case (target_code)
            `REG_CODE_CONFIG:     read_word = config_word(config_q);
            `REG_CODE_STATUS:     read_word = status_word(engine_status, config_q.page_code);
            `REG_CODE_NEXT_FREE:  read_word = next_free_word(engine_status, config_q.page_code);
            `REG_CODE_DEV_SELECT: read_word = dev_select_word(dev_select_q);
        endcase
    end

    // Access sequencing
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            bus_state_q <= cam_regs_pkg::BUS_IDLE;
        else
        begin
            unique case (bus_state_q)
                cam_regs_pkg::BUS_IDLE:
                begin
                    if (read_access)
                        bus_state_q <= cam_regs_pkg::BUS_READ;
                    else if (write_access)
                        bus_state_q <= cam_regs_pkg::BUS_WAIT_END;
                end
                cam_regs_pkg::BUS_READ:
                begin
                    bus_state_q <= access_end ? cam_regs_pkg::BUS_IDLE : cam_regs_pkg::BUS_WAIT_END;
                end
                cam_regs_pkg::BUS_WAIT_END:
                begin
                    if (access_end)
                        bus_state_q <= cam_regs_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // Read data is captured once and held until the access ends
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            dq_out_q <= 32'h0000_0000;
            dq_oe_q  <= 1'b0;
        end
        else if (bus_state_q == cam_regs_pkg::BUS_READ)
        begin
            dq_out_q <= read_word;
            dq_oe_q  <= !access_end;
        end
        else if (bus_state_q == cam_regs_pkg::BUS_IDLE || access_end)
            dq_oe_q <= 1'b0;
    end

    assign dq_out          = dq_out_q;
    assign dq_oe           = dq_oe_q;
    assign config_fields   = config_q;
    assign sw_control      = sw_control_q;
    assign device_selected = device_selected_q;

endmodule // cam_config_status_regs

/* logic/cam_regs_consts.svh */
`ifndef CAM_REGS_CONSTS_SVH
`define CAM_REGS_CONSTS_SVH

// Register select codes on the address/control bus
`define REG_CODE_CONFIG       2'h0
`define REG_CODE_STATUS       2'h1
`define REG_CODE_NEXT_FREE    2'h2
`define REG_CODE_DEV_SELECT   2'h3

// Configuration field positions
`define CFG_MASK_HI           31
`define CFG_MASK_LO           29
`define CFG_MODE_HI           27
`define CFG_MODE_LO           26
`define CFG_LPF_BIT           25
`define CFG_PAGE_HI           3
`define CFG_PAGE_LO           0

// Status field positions
`define STS_HIT_BIT           30
`define STS_MULTI_BIT         29
`define STS_FULL_BIT          28
`define STS_TYPE_HI           25
`define STS_TYPE_LO           24
`define STS_PAGE_HI           19
`define STS_PAGE_LO           16
`define STS_ADDR_HI           12
`define STS_ADDR_LO           0

// Device select field positions
`define DSEL_EN_BIT           8
`define DSEL_CODE_HI          3
`define DSEL_CODE_LO          0

// Reset values
`define RST_MASK_SRC          3'h0
`define RST_CTRL_MODE         2'h3
`define RST_LOW_PRIO          1'h1
`define RST_PAGE              4'hf
`define RST_SEL_EN_N          1'h1
`define RST_SEL_CODE          4'hf

`endif

/* logic/cam_regs_pkg.sv */
package cam_regs_pkg;

    typedef enum logic [1:0] {
        MODE_HARDWARE  = 2'h0,
        MODE_RSVD_1    = 2'h1,
        MODE_RSVD_2    = 2'h2,
        MODE_SOFTWARE  = 2'h3
    } ctrl_mode_e;

    typedef enum logic [1:0] {
        ADDR_TYPE_MATCH  = 2'h0,
        ADDR_TYPE_MEMORY = 2'h1,
        ADDR_TYPE_RSVD   = 2'h2,
        ADDR_TYPE_RESET  = 2'h3
    } addr_type_e;

    typedef enum {
        BUS_IDLE,
        BUS_READ,
        BUS_WAIT_END
    } bus_state_e;

    // Configuration fields
    typedef struct packed {
        logic [2:0] mask_source;
        ctrl_mode_e ctrl_mode;
        logic       low_priority_flag;
        logic [3:0] page_code;
    } config_s;

    // Device select fields
    typedef struct packed {
        logic       select_enable_n;
        logic [3:0] select_code;
    } dev_select_s;

    // State reported by the compare engine
    typedef struct packed {
        logic        hit_flag_n;
        logic        multi_hit_flag_n;
        logic        array_full_flag_n;
        addr_type_e  addr_type;
        logic [12:0] current_location;
        logic [12:0] next_empty_location;
    } engine_status_s;

    // Pin-side bus bundle
    typedef struct packed {
        logic        chip_enable_n;
        logic        write_n;
        logic        addr_valid_qualifier_n;
        logic [1:0]  reg_code;
        logic [31:0] data;
    } bus_pins_s;

endpackage

/* logic/pin_sync.sv */
`timescale 1ns/100ps
module pin_sync #(
    parameter int              WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    // Pin side
    input  wire logic [WIDTH-1:0] async_in,
    // Clock domain side
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;
    logic [WIDTH-1:0] sync_q;

    // Refuse a synchroniser with no bits
    if (WIDTH < 1)
    begin : g_width_check
        $error("pin_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            stage1_q <= INIT;
            stage2_q <= INIT;
            stage3_q <= INIT;
        end
        else
        begin
            stage1_q <= async_in;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // A bit changes only once the second and third stages agree
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            sync_q <= INIT;
        else
            for (int i = 0; i < WIDTH; i++)
                if (stage2_q[i] == stage3_q[i])
                    sync_q[i] <= stage3_q[i];
    end

    assign sync_out = sync_q;

endmodule // pin_sync

/* tb/cam_regs_monitor.sv */
`timescale 1ns/100ps
module cam_regs_monitor (
    // Clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         resetn,
    // Bus pins
    input  wire cam_regs_pkg::bus_pins_s      bus_pins,
    input  wire logic [31:0]                  dq_out,
    input  wire logic                         dq_oe,
    // Engine and configuration
    input  wire cam_regs_pkg::engine_status_s engine_status,
    input  wire cam_regs_pkg::config_s        config_fields,
    input  wire logic                         sw_control,
    input  wire logic                         device_selected
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    sequence read_req;
        $fell(bus_pins.chip_enable_n) ##0 bus_pins.write_n;
    endsequence
    sequence write_held;
        (!bus_pins.chip_enable_n && !bus_pins.write_n) [*8];
    endsequence

    cfg_by_write_a: assert property ($changed(config_fields) |-> !$past(bus_pins.chip_enable_n, 3)
        && !$past(bus_pins.write_n, 3)) else $error("config changed without a write");
    cfg_from_data_a: assert property ($changed(config_fields) |->
        config_fields.mask_source == $past(bus_pins.data[31:29], 2)
        && config_fields.page_code == $past(bus_pins.data[3:0], 2)) else $error("config differs from data");
    sw_mode_a: assert property (sw_control ==
        ($past(config_fields.ctrl_mode) == cam_regs_pkg::MODE_SOFTWARE)) else $error("sw_control wrong");
    sel_by_write_a: assert property ($changed(device_selected) |->
        !$past(bus_pins.chip_enable_n, 4)) else $error("selection changed without access");
    read_answer_a: assert property (read_req |-> ##[3:9] dq_oe) else $error("read not answered");
    oe_release_a: assert property ($rose(bus_pins.chip_enable_n) |-> ##[3:9] !dq_oe)
        else $error("data pins not released");
    write_quiet_a: assert property (write_held |-> !dq_oe) else $error("pins driven in write");
    rsvd_zero_a: assert property (dq_oe |-> dq_out[23:20] == 4'h0 && dq_out[15:13] == 3'h0)
        else $error("reserved read bits set");
    read_stable_a: assert property (dq_oe && $past(dq_oe) |-> $stable(dq_out))
        else $error("read data moved");
endmodule // cam_regs_monitor

bind cam_config_status_regs cam_regs_monitor i_mon (.clk_sys(clk_sys), .resetn(resetn),
    .bus_pins(bus_pins), .dq_out(dq_out), .dq_oe(dq_oe), .engine_status(engine_status),
    .config_fields(config_fields), .sw_control(sw_control), .device_selected(device_selected));

/* tb/host_bus_model.sv */
`timescale 1ns/100ps
module host_bus_model (
    // Clock
    input  wire logic                    clk_sys,
    // Device pins
    output cam_regs_pkg::bus_pins_s      bus_pins,
    input  wire logic [31:0]             dq_out,
    input  wire logic                    dq_oe
);
    initial bus_pins = '{1'b1, 1'b1, 1'b0, 2'h0, 32'h0};

    // One access; the data lines carry the inverse once released
    task automatic access(input logic wr, input logic [1:0] code, input logic qual,
                          input logic [31:0] wdata, output logic [31:0] rdata);
        int n;
        n = 0;
        rdata = 'x;
        bus_pins.write_n = !wr;
        bus_pins.reg_code = code;
        bus_pins.addr_valid_qualifier_n = qual;
        bus_pins.data = wdata;
        @(negedge clk_sys);
        bus_pins.chip_enable_n = 1'b0;
        if (wr)
            repeat (9) @(negedge clk_sys);
        else
        begin
            while (dq_oe !== 1'b1 && n < 20)
            begin
                @(negedge clk_sys);
                n++;
            end
            rdata = (dq_oe === 1'b1) ? dq_out : 'x;
        end
        bus_pins.chip_enable_n = 1'b1;
        bus_pins.data = ~wdata;
        repeat (8) @(negedge clk_sys);
    endtask
endmodule // host_bus_model

/* tb/test_cam_config_status_regs.sv */
`timescale 1ns/100ps
module test_cam_config_status_regs;
    logic                          clk_sys = 1'b0;
    logic                          resetn = 1'b0;
    cam_regs_pkg::bus_pins_s       bus_pins;
    cam_regs_pkg::engine_status_s  engine_status;
    cam_regs_pkg::config_s         config_fields;
    logic [31:0]                   dq_out;
    logic                          dq_oe;
    logic                          sw_control;
    logic                          device_selected;
    logic [31:0]                   rdata;
    logic [31:0]                   dq_out_small;
    logic                          dq_oe_small;
    logic [31:0]                   small_q;
    int                            err_total = 0;
    int                            total_checks = 0;

    always #12.5 clk_sys = ~clk_sys;

    cam_config_status_regs i_dut (.clk_sys(clk_sys), .resetn(resetn), .bus_pins(bus_pins),
        .dq_out(dq_out), .dq_oe(dq_oe), .engine_status(engine_status), .config_fields(config_fields),
        .sw_control(sw_control), .device_selected(device_selected));
    host_bus_model i_host (.clk_sys(clk_sys), .bus_pins(bus_pins), .dq_out(dq_out), .dq_oe(dq_oe));
    // Smaller-capacity variant on the same pins
    cam_config_status_regs #(.SMALL_VARIANT(1'b1)) i_dut_small (.clk_sys(clk_sys), .resetn(resetn),
        .bus_pins(bus_pins), .dq_out(dq_out_small), .dq_oe(dq_oe_small), .engine_status(engine_status),
        .config_fields(), .sw_control(), .device_selected());

    // Small variant's answer, taken while it drives the pins
    always @(negedge clk_sys)
        if (dq_oe_small === 1'b1)
            small_q = dq_out_small;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [1:0] code, input logic [31:0] d);
        i_host.access(1'b1, code, 1'b0, d, rdata);
    endtask
    task automatic rd(input logic [1:0] code, input logic q, input logic [31:0] exp);
        i_host.access(1'b0, code, q, 32'h0, rdata);
        check(rdata, exp);
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #(25 * 5000);
        err_total++;
        tally_and_finish();
    end

    initial
    begin
        engine_status = '{1'b0, 1'b1, 1'b0, cam_regs_pkg::ADDR_TYPE_MEMORY, 13'h1abc, 13'h0123};
        repeat (20) @(negedge clk_sys);
        resetn = 1'b1;
        rd(2'h0, 1'b0, 32'h0e00000f);
        rd(2'h3, 1'b0, 32'h0000010f);
        rd(2'h1, 1'b0, 32'h210f1abc);
        check(small_q, 32'h210f0abc);
        rd(2'h2, 1'b0, 32'h000f0123);
        rd(2'h0, 1'b1, 32'h210f1abc);
        wr(2'h1, 32'h0);
        rd(2'h1, 1'b0, 32'h210f1abc);
        for (int m = 0; m < 8; m++)
        begin
            wr(2'h0, {m[2:0], 29'h5});
            check({29'h0, config_fields.mask_source}, 32'(m));
        end
        check({31'h0, sw_control}, 32'h0);
        check({31'h0, config_fields.low_priority_flag}, 32'h0);
        wr(2'h0, 32'hb1fffff5);
        rd(2'h0, 1'b0, 32'ha0000005);
        rd(2'h0, 1'b1, 32'ha0000005);
        wr(2'h3, 32'hfffffef5);
        check({31'h0, device_selected}, 32'h1);
        rd(2'h3, 1'b0, 32'h00000005);
        wr(2'h0, 32'h02000006);
        check({31'h0, device_selected}, 32'h0);
        check({31'h0, config_fields.low_priority_flag}, 32'h1);
        rd(2'h1, 1'b0, 32'h21061abc);
        wr(2'h3, 32'h00000106);
        check({31'h0, device_selected}, 32'h0);
        wr(2'h3, 32'h00000006);
        check({31'h0, device_selected}, 32'h1);
        engine_status = '{1'b1, 1'b0, 1'b1, cam_regs_pkg::ADDR_TYPE_RESET, 13'h1fff, 13'h1000};
        rd(2'h1, 1'b0, 32'h53061fff);
        check(small_q, 32'h53060fff);
        rd(2'h2, 1'b0, 32'h00061000);
        check(small_q, 32'h00060000);
        engine_status = '{1'b0, 1'b0, 1'b0, cam_regs_pkg::ADDR_TYPE_MATCH, 13'h0, 13'h0};
        rd(2'h1, 1'b0, 32'h00060000);
        wr(2'h0, 32'h0e000006);
        check({31'h0, sw_control}, 32'h1);
        i_host.access(1'b1, 2'h0, 1'b1, 32'h02000009, rdata);
        rd(2'h0, 1'b1, 32'h00060000);
        rd(2'h0, 1'b0, 32'h0e000006);
        engine_status = '{1'b1, 1'b1, 1'b1, cam_regs_pkg::ADDR_TYPE_RSVD, 13'h0, 13'h0};
        rd(2'h1, 1'b0, 32'h73060000);
        resetn = 1'b0;
        repeat (2) @(negedge clk_sys);
        resetn = 1'b1;
        rd(2'h0, 1'b0, 32'h0e00000f);
        tally_and_finish();
    end
endmodule // test_cam_config_status_regs
